// >>> lsmh_pkg.sv
package lsmh_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_RXC   = 8'h04;
    localparam logic [7:0] OFF_TXC   = 8'h08;
    localparam logic [7:0] OFF_SFHDR = 8'h0C;
    localparam logic [7:0] OFF_EFHDR = 8'h10;
    localparam logic [7:0] OFF_START = 8'h14;
    localparam logic [7:0] OFF_SFDAT = 8'h40;
    localparam logic [7:0] OFF_EFDAT = 8'h80;
    localparam logic [7:0] DAT_MASK  = 8'hC0;
    // mailbox geometry and partner codes
    localparam logic [6:0] MBOX_BYTES = 7'h40;
    localparam logic [4:0] NODE_MASTER = 5'h00;
    localparam logic [4:0] NODE_MAX    = 5'h1E;
    localparam logic [4:0] NODE_BCAST  = 5'h1F;
    localparam int         PERMIT_BIT  = 0;
    // control register field positions
    localparam int CTRL_RXC_WORD  = 8;
    localparam int CTRL_TXC_WORD  = 9;
    localparam int CTRL_TXB_FLAGW = 10;
    localparam int CTRL_RXB_FLAGW = 11;
    localparam int HDR_PART_LSB  = 8;
    // reset values
    localparam logic [4:0]  RST_NODE  = 5'h01;
    localparam logic [3:0]  RST_OPTS  = 4'h0;
    localparam logic [7:0]  RST_CB    = 8'h00;
    localparam logic [15:0] RST_START = 16'h0000;
    // one-hot state codes
    typedef enum logic [1:0] {
        LSMH_TX_IDLE = 2'b01,
        LSMH_TX_SEND = 2'b10
    } lsmh_tx_t;
    typedef enum logic [1:0] {
        LSMH_RX_IDLE = 2'b01,
        LSMH_RX_FILL = 2'b10
    } lsmh_rx_t;
endpackage

// >>> lsmh_mailbox.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module lsmh_mailbox (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_first,
    output logic             tx_last,
    output logic      [7:0]  tx_data,
    output logic      [4:0]  tx_src,
    output logic      [4:0]  tx_dest,
    output logic      [6:0]  tx_len,
    input  wire logic        rx_valid,
    input  wire logic        rx_first,
    input  wire logic        rx_last,
    input  wire logic [7:0]  rx_data,
    input  wire logic [4:0]  rx_src,
    input  wire logic [4:0]  rx_dest,
    output logic             receive_permit,
    output logic             transmit_permit
);
    logic [7:0]  outgoing_mailbox [64];
    logic [7:0]  incoming_mailbox [64];
    logic [4:0]  node, next_node;
    logic [3:0]  opts, next_opts;
    logic [7:0]  receive_coord_byte, next_receive_coord_byte;
    logic [7:0]  send_coord_byte, next_send_coord_byte;
    logic [6:0]  out_len, next_out_len;
    logic [4:0]  out_dest, next_out_dest;
    logic [6:0]  in_len, next_in_len;
    logic [4:0]  in_src, next_in_src;
    logic [15:0] out_start, next_out_start;
    logic [15:0] in_start, next_in_start;
    logic [31:0] next_prdata, rd_val;
    logic        next_pready, next_pslverr, mapped;
    logic        next_tx_valid, next_tx_first, next_tx_last;
    logic [7:0]  next_tx_data;
    logic [4:0]  next_tx_dest;
    logic [6:0]  next_tx_len, tx_idx, next_tx_idx, out_eff;
    lsmh_pkg::lsmh_tx_t tx_state, next_tx_state;
    lsmh_pkg::lsmh_rx_t rx_state, next_rx_state;
    logic [6:0]  rx_cnt, next_rx_cnt;
    logic        rx_we, rx_take, out_we;
    logic [5:0]  rx_waddr;
    logic [5:0]  word;
    logic        wr;

    // merge write data into an old word under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // coordination byte sits low (flag byte) or in bits 15:8 (data word)
    function automatic logic [31:0] cb_word(input logic [7:0] cb,
                                            input logic       in_word);
        return in_word ? {16'h0000, cb, 8'h00} : {24'h000000, cb};
    endfunction

    assign word = paddr[7:2];
    assign wr   = psel & penable & pready & pwrite;
    assign receive_permit  = receive_coord_byte[lsmh_pkg::PERMIT_BIT];
    assign transmit_permit = send_coord_byte[lsmh_pkg::PERMIT_BIT];
    assign tx_src = node;
    // an out-of-range length is clamped so the walk stays inside 64 bytes
    assign out_eff = (out_len > lsmh_pkg::MBOX_BYTES) ?
                     lsmh_pkg::MBOX_BYTES : out_len;
    // a packet is taken only when addressed to us or broadcast
    assign rx_take = rx_valid & rx_first & receive_permit
                   & ((rx_dest == node) | (rx_dest == lsmh_pkg::NODE_BCAST))
                   & (rx_src != node);

    // read mux; receive mailbox hidden while the device owns it
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h00000000;
        case (paddr & ~8'h03)
            lsmh_pkg::OFF_CTRL:  rd_val = {20'h00000, opts, 3'h0, node};
            lsmh_pkg::OFF_RXC:
                rd_val = cb_word(receive_coord_byte,
                                 opts[lsmh_pkg::CTRL_RXC_WORD - 8]);
            lsmh_pkg::OFF_TXC:
                rd_val = cb_word(send_coord_byte,
                                 opts[lsmh_pkg::CTRL_TXC_WORD - 8]);
            lsmh_pkg::OFF_SFHDR: rd_val = {19'h00000, out_dest, 1'b0, out_len};
            lsmh_pkg::OFF_EFHDR: rd_val = {19'h00000, in_src, 1'b0, in_len};
            lsmh_pkg::OFF_START: rd_val = {in_start, out_start};
            default: begin
                if ((paddr & lsmh_pkg::DAT_MASK) == lsmh_pkg::OFF_SFDAT) begin
                    rd_val = {outgoing_mailbox[{word[3:0], 2'd3}],
                              outgoing_mailbox[{word[3:0], 2'd2}],
                              outgoing_mailbox[{word[3:0], 2'd1}],
                              outgoing_mailbox[{word[3:0], 2'd0}]};
                end else if ((paddr & lsmh_pkg::DAT_MASK)
                             == lsmh_pkg::OFF_EFDAT) begin
                    if (!receive_permit) begin
                        rd_val = {incoming_mailbox[{word[3:0], 2'd3}],
                                  incoming_mailbox[{word[3:0], 2'd2}],
                                  incoming_mailbox[{word[3:0], 2'd1}],
                                  incoming_mailbox[{word[3:0], 2'd0}]};
                    end
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // apb answers one cycle after setup; registers, permits, both engines
    always_comb begin
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~mapped;
        next_prdata  = (psel & ~penable) ? (pwrite ? 32'h0 : rd_val) : prdata;
        next_node = node;
        next_opts = opts;
        next_receive_coord_byte = receive_coord_byte;
        next_send_coord_byte    = send_coord_byte;
        next_out_len   = out_len;
        next_out_dest  = out_dest;
        next_in_len    = in_len;
        next_in_src    = in_src;
        next_out_start = out_start;
        next_in_start  = in_start;
        next_tx_state = tx_state;
        next_tx_valid = tx_valid;
        next_tx_first = tx_first;
        next_tx_last  = tx_last;
        next_tx_data  = tx_data;
        next_tx_dest  = tx_dest;
        next_tx_len   = tx_len;
        next_tx_idx   = tx_idx;
        next_rx_state = rx_state;
        next_rx_cnt   = rx_cnt;
        rx_we    = 1'b0;
        rx_waddr = rx_cnt[5:0];
        out_we   = 1'b0;

        // transmit engine walks the send mailbox byte by byte
        case (tx_state)
            lsmh_pkg::LSMH_TX_IDLE: begin
                if (transmit_permit) begin
                    if (out_eff == 7'h00) begin
                        next_send_coord_byte[lsmh_pkg::PERMIT_BIT] = 1'b0;
                    end else begin
                        next_tx_state = lsmh_pkg::LSMH_TX_SEND;
                        next_tx_valid = 1'b1;
                        next_tx_first = 1'b1;
                        next_tx_last  = (out_eff == 7'h01);
                        next_tx_data  = outgoing_mailbox[0];
                        next_tx_dest  = out_dest;
                        next_tx_len   = out_eff;
                        next_tx_idx   = 7'h00;
                    end
                end
            end
            lsmh_pkg::LSMH_TX_SEND: begin
                if (tx_ready) begin
                    if (tx_last) begin
                        next_tx_state = lsmh_pkg::LSMH_TX_IDLE;
                        next_tx_valid = 1'b0;
                        next_tx_last  = 1'b0;
                        next_send_coord_byte[lsmh_pkg::PERMIT_BIT] = 1'b0;
                    end else begin
                        next_tx_idx   = tx_idx + 7'h01;
                        next_tx_first = 1'b0;
                        next_tx_last  = (tx_idx + 7'h02 == tx_len);
                        next_tx_data  = outgoing_mailbox[next_tx_idx[5:0]];
                    end
                end
            end
            default: next_tx_state = lsmh_pkg::LSMH_TX_IDLE;
        endcase

        // receive engine; bytes past the end are dropped silently
        case (rx_state)
            lsmh_pkg::LSMH_RX_IDLE: begin
                if (rx_take) begin
                    rx_we       = 1'b1;
                    rx_waddr    = 6'h00;
                    next_rx_cnt = 7'h01;
                    next_in_src = rx_src;
                    if (rx_last) begin
                        next_in_len = 7'h01;
                        next_receive_coord_byte[lsmh_pkg::PERMIT_BIT] = 1'b0;
                    end else begin
                        next_rx_state = lsmh_pkg::LSMH_RX_FILL;
                    end
                end
            end
            lsmh_pkg::LSMH_RX_FILL: begin
                if (rx_valid) begin
                    if (rx_cnt < lsmh_pkg::MBOX_BYTES) begin
                        rx_we       = 1'b1;
                        next_rx_cnt = rx_cnt + 7'h01;
                    end
                    if (rx_last) begin
                        next_in_len   = next_rx_cnt;
                        next_rx_state = lsmh_pkg::LSMH_RX_IDLE;
                        next_receive_coord_byte[lsmh_pkg::PERMIT_BIT] = 1'b0;
                    end
                end
            end
            default: next_rx_state = lsmh_pkg::LSMH_RX_IDLE;
        endcase

        // software writes land after the engines: a permit write wins
        if (wr && mapped) begin
            case (paddr & ~8'h03)
                lsmh_pkg::OFF_CTRL: begin
                    if (pstrb[0] && pwdata[4:0] != lsmh_pkg::NODE_MASTER
                        && pwdata[4:0] <= lsmh_pkg::NODE_MAX) begin
                        next_node = pwdata[4:0];
                    end
                    if (pstrb[1]) begin
                        next_opts = pwdata[11:8];
                    end
                end
                lsmh_pkg::OFF_RXC: begin
                    if (opts[lsmh_pkg::CTRL_RXC_WORD - 8] ? pstrb[1]
                                                          : pstrb[0]) begin
                        next_receive_coord_byte =
                            opts[lsmh_pkg::CTRL_RXC_WORD - 8] ?
                            pwdata[15:8] : pwdata[7:0];
                    end
                end
                lsmh_pkg::OFF_TXC: begin
                    if (opts[lsmh_pkg::CTRL_TXC_WORD - 8] ? pstrb[1]
                                                          : pstrb[0]) begin
                        next_send_coord_byte =
                            opts[lsmh_pkg::CTRL_TXC_WORD - 8] ?
                            pwdata[15:8] : pwdata[7:0];
                    end
                end
                lsmh_pkg::OFF_SFHDR: begin
                    if (!transmit_permit) begin
                        if (pstrb[0]) begin
                            next_out_len = pwdata[6:0];
                        end
                        if (pstrb[1]) begin
                            next_out_dest = pwdata[12:8];
                        end
                    end
                end
                lsmh_pkg::OFF_START: begin
                    {next_in_start, next_out_start} =
                        merge({in_start, out_start}, pwdata, pstrb);
                end
                default: begin
                    out_we = ((paddr & lsmh_pkg::DAT_MASK)
                              == lsmh_pkg::OFF_SFDAT) & ~transmit_permit;
                end
            endcase
        end
    end

    // mailbox storage: send side from apb, receive side from the link
    always_ff @(posedge pclk) begin
        if (out_we) begin
            for (int i = 0; i < 4; i++) begin
                if (pstrb[i]) begin
                    outgoing_mailbox[{word[3:0], 2'(i)}] <= pwdata[i*8 +: 8];
                end
            end
        end
        if (rx_we) begin
            incoming_mailbox[rx_waddr] <= rx_data;
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            node    <= lsmh_pkg::RST_NODE;
            opts    <= lsmh_pkg::RST_OPTS;
            receive_coord_byte <= lsmh_pkg::RST_CB;
            send_coord_byte    <= lsmh_pkg::RST_CB;
            out_len   <= 7'h00;
            out_dest  <= lsmh_pkg::NODE_MASTER;
            in_len    <= 7'h00;
            in_src    <= lsmh_pkg::NODE_MASTER;
            out_start <= lsmh_pkg::RST_START;
            in_start  <= lsmh_pkg::RST_START;
            tx_state <= lsmh_pkg::LSMH_TX_IDLE;
            tx_valid <= 1'b0;
            tx_first <= 1'b0;
            tx_last  <= 1'b0;
            tx_data  <= 8'h00;
            tx_dest  <= lsmh_pkg::NODE_MASTER;
            tx_len   <= 7'h00;
            tx_idx   <= 7'h00;
            rx_state <= lsmh_pkg::LSMH_RX_IDLE;
            rx_cnt   <= 7'h00;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            node    <= next_node;
            opts    <= next_opts;
            receive_coord_byte <= next_receive_coord_byte;
            send_coord_byte    <= next_send_coord_byte;
            out_len   <= next_out_len;
            out_dest  <= next_out_dest;
            in_len    <= next_in_len;
            in_src    <= next_in_src;
            out_start <= next_out_start;
            in_start  <= next_in_start;
            tx_state <= next_tx_state;
            tx_valid <= next_tx_valid;
            tx_first <= next_tx_first;
            tx_last  <= next_tx_last;
            tx_data  <= next_tx_data;
            tx_dest  <= next_tx_dest;
            tx_len   <= next_tx_len;
            tx_idx   <= next_tx_idx;
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
        end
    end
endmodule

// >>> lsmh_checker.sv
`timescale 1ns/100ps
module lsmh_checker (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_first,
    input wire logic       tx_last,
    input wire logic [7:0] tx_data,
    input wire logic [4:0] tx_src,
    input wire logic [6:0] tx_len,
    input wire logic       rx_valid,
    input wire logic       rx_first,
    input wire logic       rx_last,
    input wire logic [4:0] rx_src,
    input wire logic [4:0] rx_dest,
    input wire logic       receive_permit,
    input wire logic       transmit_permit
);
    logic in_pkt;
    logic hit;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a packet counts only if addressed to us or broadcast, and not our own echo
    assign hit = rx_valid && rx_first && receive_permit && rx_src != tx_src
        && (rx_dest == tx_src || rx_dest == lsmh_pkg::NODE_BCAST);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) in_pkt <= 1'b0;
        else in_pkt <= (hit || in_pkt) && !(rx_valid && rx_last);
    sequence s_setup; psel && !penable; endsequence
    sequence s_last; tx_valid && tx_ready && tx_last; endsequence
    sequence s_stall; tx_valid && !tx_ready; endsequence
    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("no ready in access cycle");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_TX_OWN: assert property (tx_valid |-> transmit_permit)
        else $error("byte offered without send permit");
    AST_TX_HOLD: assert property (s_stall |=> tx_valid &&
        $stable(tx_data) && $stable(tx_last) && $stable(tx_first))
        else $error("byte changed while stalled");
    AST_TX_START: assert property ($rose(tx_valid) |->
        tx_first && $past(transmit_permit))
        else $error("packet start without permit or first mark");
    AST_TX_DONE: assert property (s_last |=>
        !tx_valid && !transmit_permit)
        else $error("send permit not cleared after last byte");
    AST_TX_NEXT: assert property (tx_valid && tx_ready && !tx_last
        |=> tx_valid && !tx_first)
        else $error("packet cut short");
    AST_TX_RANGE: assert property (tx_valid |->
        tx_len inside {[7'h01:7'h40]} && tx_src inside {[5'h01:5'h1E]})
        else $error("length or node out of range");
    AST_RX_DONE: assert property ((hit || in_pkt) && rx_valid &&
        rx_last |=> !receive_permit)
        else $error("receive permit not cleared after packet");
    AST_RX_HOLD: assert property (!receive_permit &&
        !(psel && pwrite) |=> !receive_permit)
        else $error("receive permit rose without a write");
endmodule

bind lsmh_mailbox lsmh_checker lsmh_checker_i (.*);

// >>> lsmh_net_model.sv
`timescale 1ns/100ps
module lsmh_net_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic            rx_first,
    output logic            rx_last,
    output logic      [7:0] rx_data,
    output logic      [4:0] rx_src,
    output logic      [4:0] rx_dest
);
    logic [7:0] lfsr;
    logic       busy = 1'b0;
    // taker stalls on a pseudo-random pattern when slow is set
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) begin
            lfsr     <= 8'hA5;
            tx_ready <= 1'b0;
        end else begin
            lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            tx_ready <= !slow || lfsr[0];
        end
    initial begin
        {rx_valid, rx_first, rx_last} = 3'h0;
        {rx_data, rx_src, rx_dest} = 18'h0;
    end
    // idle lines wander so a stale byte never passes for a fresh one
    always @(posedge pclk)
        if (!busy) begin
            rx_data <= ~rx_data;
            rx_src  <= ~rx_src;
            rx_dest <= ~rx_dest;
        end
    // one packet, one byte a cycle, payload base+n
    task automatic send(input logic [4:0] src, input logic [4:0] dst,
                        input int len, input logic [7:0] base);
        busy = 1'b1;
        for (int n = 0; n < len; n++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_first <= (n == 0);
            rx_last  <= (n == len - 1);
            rx_data  <= base + 8'(n);
            rx_src   <= src;
            rx_dest  <= dst;
        end
        @(posedge pclk);
        {rx_valid, rx_first, rx_last} <= 3'h0;
        busy = 1'b0;
    endtask
endmodule

// >>> tb.sv
`timescale 1ns/100ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, slow;
    logic [7:0]  paddr, tx_data, rx_data;
    logic [31:0] pwdata, prdata, rd, wd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, tx_valid, tx_ready, tx_first, tx_last;
    logic [4:0]  tx_src, tx_dest, rx_src, rx_dest;
    logic [6:0]  tx_len;
    logic        rx_valid, rx_first, rx_last;
    logic        receive_permit, transmit_permit;
    logic [7:0]  mb [64];
    logic [33:0] rd_q [$];
    logic [26:0] tx_q [$];
    logic [33:0] e;
    logic [6:0]  lens [4] = '{7'h01, 7'h40, 7'h05, 7'h00};
    logic [4:0]  dsts [4] = '{5'h00, 5'h1F, 5'h07, 5'h02};
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    lsmh_mailbox lsmh_mailbox_i (.*);
    lsmh_net_model lsmh_net_model_i (.*);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // request held until the edge that samples ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // the note is queued before the read goes out
    task automatic rdc(input logic [7:0] a, input logic [32:0] x);
        rd_q.push_back({1'b1, x});
        apb(1'b0, a, 32'h0);
    endtask

    // polling reads are noted unchecked; the timeout bounds the wait
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        do begin
            rd_q.push_back(34'h0);
            apb(1'b0, a, 32'h0);
        end while ((rd & m) != 32'h0);
    endtask

    // watcher: every read answer takes the oldest note
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            close_out();
        end
        if (psel && penable && pready && !pwrite) begin
            e = rd_q.pop_front();
            if (e[33]) cmp({1'b1, pslverr, prdata}, e);
        end
        if (tx_valid && tx_ready)
            cmp({7'h0, tx_first, tx_last, tx_dest, tx_len, tx_data, tx_src},
                {7'h0, tx_q.pop_front()});
    end

    initial begin
        {psel, penable, pwrite, slow, presetn} = 5'h0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        pstrb  = 4'hF;
        void'($urandom(32'hF932));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(lsmh_pkg::OFF_CTRL, 33'h1);
        rdc(lsmh_pkg::OFF_TXC, 33'h0);
        wr(lsmh_pkg::OFF_CTRL, 32'h0C05);
        wr(lsmh_pkg::OFF_CTRL, 32'h0C00);
        wr(lsmh_pkg::OFF_CTRL, 32'h0C1F);
        rdc(lsmh_pkg::OFF_CTRL, 33'h0C05);
        wr(lsmh_pkg::OFF_START, 32'h0040_0010);
        rdc(lsmh_pkg::OFF_START, 33'h0040_0010);
        rdc(8'h20, {1'b1, 32'h0});
        // length table covers one byte, a full box and the empty refusal
        for (int p = 0; p < 4; p++) begin
            slow <= p[0];
            for (int w = 0; w < 16; w++) begin
                wd = $urandom();
                wr(lsmh_pkg::OFF_SFDAT + 8'(4 * w), wd);
                for (int k = 0; k < 4; k++)
                    mb[4 * w + k] = wd[8 * k +: 8];
            end
            wr(lsmh_pkg::OFF_SFHDR, {19'h0, dsts[p], 1'b0, lens[p]});
            for (int n = 0; n < lens[p]; n++)
                tx_q.push_back({n == 0, n == lens[p] - 1, dsts[p], lens[p],
                                mb[n], 5'h05});
            wr(lsmh_pkg::OFF_TXC, 32'h1);
            wr(lsmh_pkg::OFF_SFDAT, 32'hFFFF_FFFF);
            poll(lsmh_pkg::OFF_TXC, 32'h1);
            cmp(34'(transmit_permit), 34'h0);
            // a one-byte or empty packet frees the box before the late write
            rdc(lsmh_pkg::OFF_SFDAT, (lens[p] > 7'h01) ?
                {1'b0, mb[3], mb[2], mb[1], mb[0]} : 33'h0_FFFF_FFFF);
        end
        cmp(34'(tx_q.size()), 34'h0);
        wr(lsmh_pkg::OFF_CTRL, 32'h0D05);
        wr(lsmh_pkg::OFF_RXC, 32'h100);
        rdc(lsmh_pkg::OFF_RXC, 33'h100);
        lsmh_net_model_i.send(5'h09, 5'h06, 8, 8'h10);
        lsmh_net_model_i.send(5'h05, 5'h1F, 8, 8'h10);
        rdc(lsmh_pkg::OFF_EFDAT, 33'h0);
        rdc(lsmh_pkg::OFF_RXC, 33'h100);
        lsmh_net_model_i.send(5'h09, 5'h05, 8, 8'h20);
        poll(lsmh_pkg::OFF_RXC, 32'h100);
        cmp(34'(receive_permit), 34'h0);
        wr(lsmh_pkg::OFF_EFHDR, 32'h1F3F);
        rdc(lsmh_pkg::OFF_EFHDR, 33'h0908);
        rdc(lsmh_pkg::OFF_EFDAT, 33'h2322_2120);
        rdc(lsmh_pkg::OFF_EFDAT + 8'h04, 33'h2726_2524);
        wr(lsmh_pkg::OFF_RXC, 32'h100);
        lsmh_net_model_i.send(5'h00, 5'h1F, 70, 8'h80);
        poll(lsmh_pkg::OFF_RXC, 32'h100);
        rdc(lsmh_pkg::OFF_EFHDR, 33'h0040);
        rdc(lsmh_pkg::OFF_EFDAT + 8'h3C, 33'hBFBE_BDBC);
        lsmh_net_model_i.send(5'h03, 5'h05, 8, 8'h00);
        rdc(lsmh_pkg::OFF_EFHDR, 33'h0040);
        repeat (4) @(posedge pclk);
        close_out();
    end
endmodule
